// >>> core/lecr_pkg.sv
package lecr_pkg;

  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned AUTO_CLEAR_NS = 1000;
  localparam int unsigned REV_BLANK_US = 350;
  localparam logic [7:0] AUTO_CLEAR_CYC =
    8'((AUTO_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] REV_BLANK_CYC =
    16'((REV_BLANK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // symbols per error-rate window; one in four errors drops lock
  localparam int unsigned RATE_WINDOW = 16;
  localparam int unsigned RATE_DIVISOR = 4;

  // register offsets
  localparam logic [7:0] OFS_SER_ADDR = 8'h00;
  localparam logic [7:0] OFS_DES_ADDR = 8'h01;
  localparam logic [7:0] OFS_CC_EN = 8'h04;
  localparam logic [7:0] OFS_ERR_CTL = 8'h08;
  localparam logic [7:0] OFS_PIN_CTL = 8'h0e;
  localparam logic [7:0] OFS_DET_CNT = 8'h10;
  localparam logic [7:0] OFS_CORR_CNT = 8'h12;
  localparam logic [7:0] OFS_PRBS_CNT = 8'h13;

  // field positions
  localparam int unsigned BIT_FWD_EN = 0;
  localparam int unsigned BIT_REV_EN = 1;
  localparam int unsigned BIT_WR_LOCK = 4;
  localparam int unsigned BIT_AUTO_CLR = 2;
  localparam int unsigned BIT_STAG_DIS = 3;
  localparam int unsigned BIT_PIN_A_LVL = 0;
  localparam int unsigned BIT_PIN_A_DRV = 1;
  localparam int unsigned BIT_PIN_B_LVL = 2;
  localparam int unsigned BIT_PIN_B_DRV = 3;

  // values after reset
  localparam logic [7:0] SER_ADDR_RESET = 8'h80;
  localparam logic [7:0] DES_ADDR_RESET = 8'h90;
  localparam logic CC_EN_RESET = 1'b1;
  localparam logic AUTO_CLR_RESET = 1'b0;
  localparam logic STAG_DIS_RESET = 1'b0;
  localparam logic PIN_DRV_RESET = 1'b1;

  typedef enum logic [2:0] {
    LECR_HUNT = 3'b001,
    LECR_LOCKED = 3'b010,
    LECR_DROP = 3'b100
  } lecr_lock_e;

  typedef enum logic [1:0] {
    LECR_CABLE_LOW = 2'b00,
    LECR_CABLE_MID = 2'b01,
    LECR_CABLE_HIGH = 2'b10
  } lecr_cable_e;

  typedef struct packed {
    logic [7:0] ser_addr;
    logic [7:0] des_addr;
    logic fwd_en;
    logic rev_en;
    logic wr_lock;
    logic auto_clear_en;
    logic stagger_dis;
    logic pin_a_oe;
    logic pin_b_oe;
    logic pin_a_level;
    logic pin_b_level;
    lecr_lock_e lock_st;
    logic lock;
    logic err_oe;
    logic [7:0] ac_timer;
    logic [15:0] blank_cnt;
    logic link_en_d;
    logic fwd_avail;
    logic rev_avail;
    logic cc_ack;
    logic [7:0] rdata;
    logic rvalid;
    logic cable_done;
    lecr_cable_e cable;
    logic stagger_en;
  } lecr_state_s;

endpackage : lecr_pkg

// >>> core/lecr_sat_counter.sv
`timescale 1ns/1ps
`default_nettype none
module lecr_sat_counter #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic inc_in,
  input wire logic clear_in,
  input wire logic hold_zero_in,
  input wire logic freeze_in,
  output logic [WIDTH-1:0] count_out
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
  } lecr_cnt_state_s;

  lecr_cnt_state_s st;
  lecr_cnt_state_s next_st;

  always_comb
  begin
    next_st = st;
    if (hold_zero_in)
    begin
      next_st.count = '0;
    end
    else if (inc_in && !freeze_in)
    begin
      // an error in the clearing cycle is kept, not lost
      if (clear_in)
        next_st.count = WIDTH'(1);
      else if (st.count != '1)
        next_st.count = st.count + WIDTH'(1);
    end
    else if (clear_in)
    begin
      next_st.count = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign count_out = st.count;
endmodule : lecr_sat_counter
`default_nettype wire

// >>> core/lecr_rate_mon.sv
`timescale 1ns/1ps
`default_nettype none
module lecr_rate_mon #(
  parameter int unsigned WINDOW = 16,
  parameter int unsigned DIVISOR = 4
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic active_in,
  input wire logic sym_valid_in,
  input wire logic code_err_in,
  output logic too_many_out
);
  localparam int unsigned CW = $clog2(WINDOW + 1);

  typedef struct packed {
    logic [CW-1:0] syms;
    logic [CW-1:0] errs;
    logic bad;
  } lecr_rate_state_s;

  lecr_rate_state_s st;
  lecr_rate_state_s next_st;
  logic [CW-1:0] errs_now;

  always_comb
  begin
    next_st = st;
    errs_now = st.errs + CW'(code_err_in);
    next_st.bad = 1'b0;
    if (!active_in)
    begin
      next_st.syms = '0;
      next_st.errs = '0;
    end
    else if (sym_valid_in)
    begin
      if (st.syms == CW'(WINDOW - 1))
      begin
        // rate of one in DIVISOR or worse over the window
        next_st.bad = (32'(errs_now) * DIVISOR) >= WINDOW;
        next_st.syms = '0;
        next_st.errs = '0;
      end
      else
      begin
        next_st.syms = st.syms + CW'(1);
        next_st.errs = errs_now;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      st <= '0;
    else if (ce_in)
      st <= next_st;
  end

  assign too_many_out = st.bad;
endmodule : lecr_rate_mon
`default_nettype wire

// >>> core/lecr_top.sv
// Function
// - two 8-bit error counters, detected and corrected
// - quarter error rate drops lock, freezes, relocks
// - counters clear on video-link lock, read, auto clear
// - prbs test uses own counter, normal held zero
// - error pin low above threshold or prbs error
// - error pin released whenever counters clear
// - auto clear about one microsecond after low
// - auto clear off at reset, control bit enables
// - no auto clear during prbs test
// - channel enable bits; both off blocks traffic
// - contention gives no acknowledge, no arbitration
// - reverse channel blocked after link start/stop
// - lock shown for video link only
// - serializer and deserializer address registers
// - three-level cable input decoded at startup
// - write lock holds until power-down or reset
// - drive bits pull pins low or release
// - pin levels always sampled and readable
// - outputs staggered unless disable bit set
`timescale 1ns/1ps
`default_nettype none
module lecr_top #(
  parameter logic [15:0] REV_BLANK_CYCLES = lecr_pkg::REV_BLANK_CYC,
  parameter int unsigned RATE_WINDOW = lecr_pkg::RATE_WINDOW
) (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic REG_RVALID_OUT,
  input wire logic [7:0] DET_THRESH_IN,
  input wire logic [7:0] CORR_THRESH_IN,
  input wire logic SYMBOL_VALID_IN,
  input wire logic CODE_ERR_IN,
  input wire logic DET_ERR_IN,
  input wire logic CORR_ERR_IN,
  input wire logic PRBS_TEST_IN,
  input wire logic PRBS_ERR_IN,
  input wire logic CDR_LOCK_IN,
  input wire logic VIDEO_LINK_IN,
  input wire logic SERIAL_LINK_EN_IN,
  input wire logic POWER_DOWN_N_IN,
  input wire logic [1:0] CABLE_TYPE_SELECT_IN,
  input wire logic CC_XFER_DONE_IN,
  input wire logic CC_CONTENTION_IN,
  input wire logic PIN_A_IN,
  input wire logic PIN_B_IN,
  output logic PIN_A_OUT,
  output logic PIN_A_OE_OUT,
  output logic PIN_B_OUT,
  output logic PIN_B_OE_OUT,
  output logic ERR_OUT,
  output logic ERR_OE_OUT,
  output logic LOCK_OUT,
  output logic RELOCK_REQ_OUT,
  output logic FWD_CHANNEL_OUT,
  output logic REV_CHANNEL_OUT,
  output logic CC_ACK_OUT,
  output logic STAGGER_EN_OUT,
  output logic [1:0] CABLE_LEVEL_OUT
);
  lecr_pkg::lecr_state_s st;
  lecr_pkg::lecr_state_s next_st;

  logic [7:0] detected_error_count;
  logic [7:0] corrected_error_count;
  logic [7:0] prbs_error_count;
  logic rate_bad;
  logic locked;
  logic lock_gain;
  logic rd_det;
  logic rd_corr;
  logic rd_prbs;
  logic auto_clear;
  logic clr_det;
  logic clr_corr;
  logic wr_ok;

  assign locked = (st.lock_st == lecr_pkg::LECR_LOCKED);
  // a counter read is taken as successful readout and clears it
  assign rd_det = CLK_EN_IN && REG_RD_IN && (REG_ADDR_IN == lecr_pkg::OFS_DET_CNT);
  assign rd_corr = CLK_EN_IN && REG_RD_IN && (REG_ADDR_IN == lecr_pkg::OFS_CORR_CNT);
  assign rd_prbs = CLK_EN_IN && REG_RD_IN && (REG_ADDR_IN == lecr_pkg::OFS_PRBS_CNT);
  assign lock_gain = (st.lock_st == lecr_pkg::LECR_HUNT) && CDR_LOCK_IN && VIDEO_LINK_IN;
  assign auto_clear = st.auto_clear_en && !PRBS_TEST_IN && st.err_oe
    && (st.ac_timer == lecr_pkg::AUTO_CLEAR_CYC - 8'h01);
  assign clr_det = lock_gain || rd_det || auto_clear;
  assign clr_corr = lock_gain || rd_corr || auto_clear;
  assign wr_ok = CLK_EN_IN && REG_WR_IN && !st.wr_lock;

  lecr_rate_mon #(
    .WINDOW(RATE_WINDOW),
    .DIVISOR(lecr_pkg::RATE_DIVISOR)
  ) u_rate (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CLK_EN_IN),
    .active_in(locked),
    .sym_valid_in(SYMBOL_VALID_IN),
    .code_err_in(CODE_ERR_IN),
    .too_many_out(rate_bad)
  );

  lecr_sat_counter #(.WIDTH(8)) u_det (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CLK_EN_IN),
    .inc_in(DET_ERR_IN),
    .clear_in(clr_det),
    .hold_zero_in(PRBS_TEST_IN),
    .freeze_in(!locked),
    .count_out(detected_error_count)
  );

  lecr_sat_counter #(.WIDTH(8)) u_corr (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CLK_EN_IN),
    .inc_in(CORR_ERR_IN),
    .clear_in(clr_corr),
    .hold_zero_in(PRBS_TEST_IN),
    .freeze_in(!locked),
    .count_out(corrected_error_count)
  );

  lecr_sat_counter #(.WIDTH(8)) u_prbs (
    .clk_in(CLOCK_IN),
    .rstn_in(RSTN_IN),
    .ce_in(CLK_EN_IN),
    .inc_in(PRBS_ERR_IN && PRBS_TEST_IN),
    .clear_in(rd_prbs),
    .hold_zero_in(1'b0),
    .freeze_in(1'b0),
    .count_out(prbs_error_count)
  );

  always_comb
  begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.cc_ack = 1'b0;

    // strap caught once, on the first enabled edge after reset
    if (!st.cable_done)
    begin
      next_st.cable_done = 1'b1;
      case (CABLE_TYPE_SELECT_IN)
        2'b11: next_st.cable = lecr_pkg::LECR_CABLE_HIGH;
        2'b00: next_st.cable = lecr_pkg::LECR_CABLE_LOW;
        default: next_st.cable = lecr_pkg::LECR_CABLE_MID;
      endcase
    end

    // lock tracking; detected and corrected counters only run while locked, the prbs counter runs regardless
    case (st.lock_st)
      lecr_pkg::LECR_HUNT:
      begin
        if (CDR_LOCK_IN)
          next_st.lock_st = lecr_pkg::LECR_LOCKED;
      end
      lecr_pkg::LECR_LOCKED:
      begin
        if (rate_bad)
          next_st.lock_st = lecr_pkg::LECR_DROP;
        else if (!CDR_LOCK_IN)
          next_st.lock_st = lecr_pkg::LECR_HUNT;
      end
      lecr_pkg::LECR_DROP:
      begin
        // hold the relock request until the recovery loop lets go
        if (!CDR_LOCK_IN)
          next_st.lock_st = lecr_pkg::LECR_HUNT;
      end
      default: next_st.lock_st = lecr_pkg::LECR_HUNT;
    endcase
    next_st.lock = (next_st.lock_st == lecr_pkg::LECR_LOCKED) && VIDEO_LINK_IN;

    // error pin; a clear in this cycle releases it for at least one cycle
    if (clr_det || clr_corr || rd_prbs)
      next_st.err_oe = 1'b0;
    else if (PRBS_TEST_IN)
      next_st.err_oe = (prbs_error_count != 8'h00);
    else
      next_st.err_oe = (detected_error_count > DET_THRESH_IN)
        || (corrected_error_count > CORR_THRESH_IN);
    if (st.err_oe && st.auto_clear_en && !PRBS_TEST_IN && !auto_clear)
      next_st.ac_timer = st.ac_timer + 8'h01;
    else
      next_st.ac_timer = 8'h00;

    // reverse channel blanking after any start or stop of the link
    next_st.link_en_d = SERIAL_LINK_EN_IN;
    if (SERIAL_LINK_EN_IN != st.link_en_d)
      next_st.blank_cnt = REV_BLANK_CYCLES;
    else if (st.blank_cnt != 16'h0000)
      next_st.blank_cnt = st.blank_cnt - 16'h0001;

    // register writes, all refused once the lock is set
    if (wr_ok)
    begin
      case (REG_ADDR_IN)
        lecr_pkg::OFS_SER_ADDR: next_st.ser_addr = REG_WDATA_IN;
        lecr_pkg::OFS_DES_ADDR: next_st.des_addr = REG_WDATA_IN;
        lecr_pkg::OFS_CC_EN:
        begin
          next_st.fwd_en = REG_WDATA_IN[lecr_pkg::BIT_FWD_EN];
          next_st.rev_en = REG_WDATA_IN[lecr_pkg::BIT_REV_EN];
          next_st.wr_lock = REG_WDATA_IN[lecr_pkg::BIT_WR_LOCK];
        end
        lecr_pkg::OFS_ERR_CTL:
        begin
          next_st.auto_clear_en = REG_WDATA_IN[lecr_pkg::BIT_AUTO_CLR];
          next_st.stagger_dis = REG_WDATA_IN[lecr_pkg::BIT_STAG_DIS];
        end
        lecr_pkg::OFS_PIN_CTL:
        begin
          next_st.pin_a_oe = !REG_WDATA_IN[lecr_pkg::BIT_PIN_A_DRV];
          next_st.pin_b_oe = !REG_WDATA_IN[lecr_pkg::BIT_PIN_B_DRV];
        end
        default: next_st.ser_addr = st.ser_addr;
      endcase
    end
    if (!POWER_DOWN_N_IN)
      next_st.wr_lock = 1'b0;

    next_st.fwd_avail = next_st.fwd_en;
    next_st.rev_avail = next_st.rev_en && (next_st.blank_cnt == 16'h0000);
    // colliding transfers are dropped silently; neither side wins
    next_st.cc_ack = CC_XFER_DONE_IN && !CC_CONTENTION_IN
      && (st.fwd_avail || st.rev_avail);
    next_st.stagger_en = !next_st.stagger_dis;

    // pin levels sampled every cycle, whatever the drive bits say
    next_st.pin_a_level = PIN_A_IN;
    next_st.pin_b_level = PIN_B_IN;

    if (REG_RD_IN)
    begin
      next_st.rvalid = 1'b1;
      case (REG_ADDR_IN)
        lecr_pkg::OFS_SER_ADDR: next_st.rdata = st.ser_addr;
        lecr_pkg::OFS_DES_ADDR: next_st.rdata = st.des_addr;
        lecr_pkg::OFS_CC_EN: next_st.rdata = {3'b000, st.wr_lock, 2'b00, st.rev_en, st.fwd_en};
        lecr_pkg::OFS_ERR_CTL: next_st.rdata = {4'h0, st.stagger_dis, st.auto_clear_en, 2'b00};
        lecr_pkg::OFS_PIN_CTL: next_st.rdata = {4'h0, !st.pin_b_oe, st.pin_b_level,
          !st.pin_a_oe, st.pin_a_level};
        lecr_pkg::OFS_DET_CNT: next_st.rdata = detected_error_count;
        lecr_pkg::OFS_CORR_CNT: next_st.rdata = corrected_error_count;
        lecr_pkg::OFS_PRBS_CNT: next_st.rdata = prbs_error_count;
        default: next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      st <= '0;
      st.ser_addr <= lecr_pkg::SER_ADDR_RESET;
      st.des_addr <= lecr_pkg::DES_ADDR_RESET;
      st.fwd_en <= lecr_pkg::CC_EN_RESET;
      st.rev_en <= lecr_pkg::CC_EN_RESET;
      st.fwd_avail <= lecr_pkg::CC_EN_RESET;
      st.auto_clear_en <= lecr_pkg::AUTO_CLR_RESET;
      st.stagger_dis <= lecr_pkg::STAG_DIS_RESET;
      st.stagger_en <= !lecr_pkg::STAG_DIS_RESET;
      st.pin_a_oe <= !lecr_pkg::PIN_DRV_RESET;
      st.pin_b_oe <= !lecr_pkg::PIN_DRV_RESET;
      st.lock_st <= lecr_pkg::LECR_HUNT;
      st.cable <= lecr_pkg::LECR_CABLE_MID;
    end
    else if (CLK_EN_IN)
    begin
      st <= next_st;
    end
  end

  // open-drain pins: data is a constant low, only the enables move
  assign PIN_A_OUT = 1'b0;
  assign PIN_B_OUT = 1'b0;
  assign ERR_OUT = 1'b0;
  assign PIN_A_OE_OUT = st.pin_a_oe;
  assign PIN_B_OE_OUT = st.pin_b_oe;
  assign ERR_OE_OUT = st.err_oe;
  assign REG_RDATA_OUT = st.rdata;
  assign REG_RVALID_OUT = st.rvalid;
  assign LOCK_OUT = st.lock;
  assign RELOCK_REQ_OUT = st.lock_st[2];
  assign FWD_CHANNEL_OUT = st.fwd_avail;
  assign REV_CHANNEL_OUT = st.rev_avail;
  assign CC_ACK_OUT = st.cc_ack;
  assign STAGGER_EN_OUT = st.stagger_en;
  assign CABLE_LEVEL_OUT = st.cable;
endmodule : lecr_top
`default_nettype wire

// >>> sim/lecr_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
module lecr_chk (
  input wire logic CLOCK_IN,
  input wire logic RSTN_IN,
  input wire logic CLK_EN_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_RDATA_OUT,
  input wire logic REG_RVALID_OUT,
  input wire logic PRBS_TEST_IN,
  input wire logic PRBS_ERR_IN,
  input wire logic VIDEO_LINK_IN,
  input wire logic SERIAL_LINK_EN_IN,
  input wire logic CC_XFER_DONE_IN,
  input wire logic CC_CONTENTION_IN,
  input wire logic ERR_OE_OUT,
  input wire logic LOCK_OUT,
  input wire logic REV_CHANNEL_OUT,
  input wire logic CC_ACK_OUT
);
  default clocking cb @(posedge CLOCK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  logic rd_take;
  assign rd_take = REG_RD_IN && CLK_EN_IN;
  sequence s_det_read;
    rd_take && REG_ADDR_IN == 8'h10 && !PRBS_TEST_IN;
  endsequence
  sequence s_link_edge;
    CLK_EN_IN && $changed(SERIAL_LINK_EN_IN);
  endsequence
  chk_read_answer: assert property (rd_take |=> REG_RVALID_OUT)
    else $error("read gave no answer");
  chk_rvalid_cause: assert property (REG_RVALID_OUT |-> $past(rd_take))
    else $error("answer without read");
  chk_rdata_hold: assert property (!$past(rd_take) |-> $stable(REG_RDATA_OUT))
    else $error("read data moved without read");
  chk_err_release: assert property (s_det_read |=> !ERR_OE_OUT)
    else $error("error pin held after counter read");
  chk_prbs_err: assert property (PRBS_TEST_IN && PRBS_ERR_IN && CLK_EN_IN |-> ##[1:3] ERR_OE_OUT)
    else $error("prbs error not flagged");
  chk_lock_video: assert property (CLK_EN_IN && !VIDEO_LINK_IN |=> !LOCK_OUT)
    else $error("lock shown on config link");
  chk_ack_contend: assert property (CC_XFER_DONE_IN && CC_CONTENTION_IN && CLK_EN_IN |=> !CC_ACK_OUT)
    else $error("acknowledge despite contention");
  chk_rev_blank: assert property (s_link_edge |=> ##1 !REV_CHANNEL_OUT [*7])
    else $error("reverse channel open after link edge");
endmodule : lecr_chk
bind lecr_top lecr_chk chk_u (.CLOCK_IN(CLOCK_IN), .RSTN_IN(RSTN_IN), .CLK_EN_IN(CLK_EN_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .REG_RVALID_OUT(REG_RVALID_OUT), .PRBS_TEST_IN(PRBS_TEST_IN), .PRBS_ERR_IN(PRBS_ERR_IN),
  .VIDEO_LINK_IN(VIDEO_LINK_IN), .SERIAL_LINK_EN_IN(SERIAL_LINK_EN_IN),
  .CC_XFER_DONE_IN(CC_XFER_DONE_IN), .CC_CONTENTION_IN(CC_CONTENTION_IN),
  .ERR_OE_OUT(ERR_OE_OUT), .LOCK_OUT(LOCK_OUT), .REV_CHANNEL_OUT(REV_CHANNEL_OUT),
  .CC_ACK_OUT(CC_ACK_OUT));
`default_nettype wire

// >>> sim/lecr_ser_model.sv
`timescale 1ns/1ps
`default_nettype none
module lecr_ser_model #(
  parameter int unsigned LOCK_DLY = 12
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic bad_in,
  input wire logic relock_in,
  output logic sym_valid_out,
  output logic code_err_out,
  output logic cdr_lock_out
);
  logic [3:0] up_cnt;
  // slow lock on purpose, so a relock leaves a real gap
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      up_cnt <= 4'h0;
      sym_valid_out <= 1'b0;
    end
    else
    begin
      // fixed symbol pace: the channel rate never takes a step near 3.5x
      sym_valid_out <= run_in && !sym_valid_out;
      if (!run_in || relock_in)
        up_cnt <= 4'h0;
      else if (up_cnt != 4'(LOCK_DLY))
        up_cnt <= up_cnt + 4'h1;
    end
  end
  assign cdr_lock_out = run_in && up_cnt == 4'(LOCK_DLY);
  assign code_err_out = sym_valid_out && bad_in;
endmodule : lecr_ser_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0, rstn = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, det_thr = 8'h02, corr_thr = 8'h00;
  logic [3:0] ev = 4'h0;
  logic prbs_test = 1'b0, video = 1'b1, link_en = 1'b1, pdn_n = 1'b1, cc_cont = 1'b0;
  logic bad = 1'b0, sym_v, code_e, cdr_lock, pin_a, pin_b;
  logic [1:0] cable = 2'b11, cable_lvl;
  logic [1:0] cab_in [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
  logic [1:0] cab_exp [4] = '{2'b00, 2'b01, 2'b10, 2'b01};
  logic [7:0] rdata;
  logic rvalid, pa_oe, pb_oe, err_oe, lock, relock, fwd, rev, ack, stag;
  logic pa_o, pb_o, err_o;
  logic [3:0] obs;
  int error_cnt = 0, tests_run = 0, n;
  always #5 clk = ~clk;
  // open-drain pins: released pins float high on their pull-ups
  assign pin_a = pa_oe ? 1'b0 : 1'b1;
  assign pin_b = pb_oe ? 1'b0 : 1'b1;
  assign obs = {rev, relock, lock, err_oe};
  lecr_ser_model #(.LOCK_DLY(12)) ser_u (.clk_in(clk), .rstn_in(rstn), .run_in(link_en),
    .bad_in(bad), .relock_in(relock), .sym_valid_out(sym_v), .code_err_out(code_e),
    .cdr_lock_out(cdr_lock));
  lecr_top #(.REV_BLANK_CYCLES(16'h0014), .RATE_WINDOW(8)) dut_u (.CLOCK_IN(clk),
    .RSTN_IN(rstn), .CLK_EN_IN(clk_en), .REG_ADDR_IN(addr), .REG_WR_IN(reg_wr),
    .REG_RD_IN(reg_rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
    .DET_THRESH_IN(det_thr), .CORR_THRESH_IN(corr_thr), .SYMBOL_VALID_IN(sym_v),
    .CODE_ERR_IN(code_e), .DET_ERR_IN(ev[0]), .CORR_ERR_IN(ev[1]), .PRBS_TEST_IN(prbs_test),
    .PRBS_ERR_IN(ev[2]), .CDR_LOCK_IN(cdr_lock), .VIDEO_LINK_IN(video),
    .SERIAL_LINK_EN_IN(link_en), .POWER_DOWN_N_IN(pdn_n), .CABLE_TYPE_SELECT_IN(cable),
    .CC_XFER_DONE_IN(ev[3]), .CC_CONTENTION_IN(cc_cont), .PIN_A_IN(pin_a), .PIN_B_IN(pin_b),
    .PIN_A_OUT(pa_o), .PIN_A_OE_OUT(pa_oe), .PIN_B_OUT(pb_o), .PIN_B_OE_OUT(pb_oe),
    .ERR_OUT(err_o),
    .ERR_OE_OUT(err_oe), .LOCK_OUT(lock), .RELOCK_REQ_OUT(relock), .FWD_CHANNEL_OUT(fwd),
    .REV_CHANNEL_OUT(rev), .CC_ACK_OUT(ack), .STAGGER_EN_OUT(stag),
    .CABLE_LEVEL_OUT(cable_lvl));

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // every wait is bounded; running out ends the run as a failure
  task automatic wait_for(input int sel, input logic v, input int lim);
    n = 0;
    while (obs[sel] !== v)
    begin
      if (n == lim)
      begin
        chk(obs[sel], v);
        give_verdict();
      end
      tick();
      n++;
    end
  endtask : wait_for

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    reg_wr = 1'b1;
    tick();
    reg_wr = 1'b0;
    tick();
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    reg_rd = 1'b1;
    tick();
    reg_rd = 1'b0;
    if (rvalid !== 1'b1)
      tick();
    chk(rvalid, 1'b1);
    chk(rdata, e);
    tick();
  endtask : rd_chk

  task automatic pulse(input int sel, input int cnt);
    repeat (cnt)
    begin
      ev[sel] = 1'b1;
      tick();
      ev = 4'h0;
      tick();
    end
  endtask : pulse

  task automatic cc(input logic cont, input logic e);
    ev[3] = 1'b1;
    cc_cont = cont;
    tick();
    ev = 4'h0;
    cc_cont = 1'b0;
    chk(ack, e);
    tick();
  endtask : cc

  task automatic t_cable();
    for (int k = 0; k < 4; k++)
    begin
      cable = cab_in[k];
      rstn = 1'b0;
      repeat (16) tick();
      rstn = 1'b1;
      tick();
      tick();
      chk(cable_lvl, cab_exp[k]);
    end
    $display("cable strap done");
  endtask : t_cable

  task automatic t_regs();
    chk(stag, 1'b1);
    chk({pa_o, pb_o, err_o}, 3'b000);
    rd_chk(8'h00, 8'h80);
    rd_chk(8'h01, 8'h90);
    rd_chk(8'h04, 8'h03);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h0e, 8'h0f);
    wr(8'h0e, 8'h00);
    chk({pa_oe, pb_oe}, 2'b11);
    rd_chk(8'h0e, 8'h00);
    wr(8'h0e, 8'h0a);
    chk({pa_oe, pb_oe}, 2'b00);
    wr(8'h00, 8'h5a);
    rd_chk(8'h00, 8'h5a);
    wr(8'h01, 8'h92);
    rd_chk(8'h01, 8'h92);
    wr(8'h08, 8'h08);
    chk(stag, 1'b0);
    wr(8'h08, 8'h00);
    $display("registers done");
  endtask : t_regs

  task automatic t_count();
    wait_for(1, 1'b1, 200);
    rd_chk(8'h10, 8'h00);
    pulse(0, 2);
    tick();
    chk(err_oe, 1'b0);
    pulse(0, 1);
    wait_for(0, 1'b1, 4);
    rd_chk(8'h10, 8'h03);
    chk(err_oe, 1'b0);
    rd_chk(8'h10, 8'h00);
    // events while the clock enable is low must leave no trace
    clk_en = 1'b0;
    pulse(0, 4);
    clk_en = 1'b1;
    tick();
    chk(err_oe, 1'b0);
    rd_chk(8'h10, 8'h00);
    pulse(1, 1);
    wait_for(0, 1'b1, 4);
    rd_chk(8'h12, 8'h01);
    ev[0] = 1'b1;
    repeat (260) tick();
    ev = 4'h0;
    tick();
    rd_chk(8'h10, 8'hff);
    $display("counting done");
  endtask : t_count

  task automatic t_auto();
    wr(8'h08, 8'h04);
    rd_chk(8'h08, 8'h04);
    pulse(1, 1);
    wait_for(0, 1'b1, 4);
    wait_for(0, 1'b0, 200);
    chk(n >= 95 && n <= 105, 1'b1);
    rd_chk(8'h12, 8'h00);
    prbs_test = 1'b1;
    pulse(0, 2);
    pulse(2, 1);
    wait_for(0, 1'b1, 4);
    repeat (150) tick();
    chk(err_oe, 1'b1);
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h13, 8'h01);
    prbs_test = 1'b0;
    $display("auto clear done");
  endtask : t_auto

  task automatic t_lock();
    bad = 1'b1;
    wait_for(2, 1'b1, 100);
    bad = 1'b0;
    video = 1'b0;
    pulse(0, 2);
    chk(lock, 1'b0);
    repeat (30) tick();
    chk(lock, 1'b0);
    pulse(0, 1);
    rd_chk(8'h10, 8'h01);
    video = 1'b1;
    wait_for(1, 1'b1, 5);
    $display("lock done");
  endtask : t_lock

  task automatic t_wlock();
    wr(8'h04, 8'h13);
    wr(8'h00, 8'h11);
    rd_chk(8'h00, 8'h5a);
    wr(8'h04, 8'h03);
    rd_chk(8'h04, 8'h13);
    pdn_n = 1'b0;
    tick();
    pdn_n = 1'b1;
    wr(8'h00, 8'h22);
    rd_chk(8'h00, 8'h22);
    $display("write lock done");
  endtask : t_wlock

  task automatic t_cc();
    cc(1'b0, 1'b1);
    cc(1'b1, 1'b0);
    wr(8'h04, 8'h00);
    chk({fwd, rev}, 2'b00);
    cc(1'b0, 1'b0);
    wr(8'h04, 8'h03);
    link_en = 1'b0;
    tick();
    tick();
    chk(rev, 1'b0);
    repeat (30) tick();
    link_en = 1'b1;
    wait_for(3, 1'b0, 3);
    wait_for(3, 1'b1, 40);
    chk(n >= 17 && n <= 22, 1'b1);
    $display("control channel done");
  endtask : t_cc

  initial
  begin
    t_cable();
    t_regs();
    t_count();
    t_auto();
    t_lock();
    t_wlock();
    t_cc();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
